// ---- ledpi_defs.svh ----
// constants for the led current pi regulator
`ifndef LEDPI_DEFS_SVH
`define LEDPI_DEFS_SVH
`define LEDPI_ADDR_CTRL    6'h00
`define LEDPI_ADDR_THRESH  6'h04
`define LEDPI_ADDR_TGT0    6'h08
`define LEDPI_ADDR_TGT1    6'h0C
`define LEDPI_ADDR_TGT2    6'h10
`define LEDPI_ADDR_STATUS  6'h14
`define LEDPI_ADDR_DUTY0   6'h18
`define LEDPI_ADDR_DUTY1   6'h1C
`define LEDPI_ADDR_DUTY2   6'h20
`define LEDPI_CTRL_EN      0
`define LEDPI_ST_OC_LSB    0
`define LEDPI_ST_BUSY      4
`define LEDPI_ST_CH_LSB    8
`define LEDPI_RST_THRESH   13'h1FFF
`define LEDPI_COEF_A1      32'sh000000B9
`define LEDPI_COEF_A2      32'sh00000020
`define LEDPI_DUTY_MAX     24'hFFF000
`define LEDPI_FB_SHIFT     6
`define LEDPI_FB_MASK      16'h03FE
`define LEDPI_TGT_SHIFT    3
`define LEDPI_OUT_SHIFT    8
`define LEDPI_SETTLE_LAST  5'h13
`define LEDPI_LAST_CH      2'h2
`endif

// ---- ledpi_pkg.sv ----
// types of the led current pi regulator
package ledpi_pkg;
   typedef enum logic [5:0] {
      LEDPI_IDLE   = 6'h01,
      LEDPI_SETTLE = 6'h02,
      LEDPI_CONV   = 6'h04,
      LEDPI_WAITC  = 6'h08,
      LEDPI_CALC   = 6'h10,
      LEDPI_LOAD   = 6'h20
   } ledpi_state_e_t;

   typedef struct packed {
      logic [5:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } ledpi_bus_t;

   typedef struct packed {
      logic [1:0]  channel;
      logic [15:0] duty;
      logic        trigger;
   } ledpi_pwm_t;

   typedef struct packed {
      ledpi_state_e_t    state;
      logic [1:0]        ch;
      logic [4:0]        cnt;
      logic              enable;
      logic [12:0]       thresh;
      logic [2:0][9:0]   tgt;
      logic [2:0]        oc;
      logic [2:0]        first_done;
      logic [2:0][9:0]   offset;
      logic [2:0][9:0]   fb_old;
      logic [2:0][23:0]  duty;
      logic [9:0]        fb;
      logic              tick_d;
      logic [31:0]       rdata;
      ledpi_pwm_t        pwm;
   } ledpi_core_t;
endpackage : ledpi_pkg

// ---- ledpi_sync.sv ----
// two flip-flop synchroniser for the interval tick pin
`timescale 1ns/1ps
module ledpi_sync import ledpi_pkg::*; (
   input  wire logic clock,
   input  wire logic rst_b,
   input  wire logic async_in,
   output logic      sync_out
);
   logic [1:0] s_reg;
   logic [1:0] s_next;

   // stage one feeds stage two only
   always_comb begin
      s_next = {s_reg[0], async_in};
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         s_reg <= 2'h0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign sync_out = s_reg[1];
endmodule : ledpi_sync

// ---- ledpi_duty_step.sv ----
// clamped duty accumulator step
`timescale 1ns/1ps
`include "ledpi_defs.svh"
module ledpi_duty_step import ledpi_pkg::*; (
   input  wire logic [23:0]        duty_prev,
   input  wire logic signed [31:0] err_sum,
   input  wire logic               tgt_zero,
   output logic [23:0]             duty_next
);
   logic signed [33:0] sum;

   // add the correction, pin to max or zero at the ends
   always_comb begin
      sum = $signed({10'h000, duty_prev}) + 34'(err_sum);
      if (err_sum > 32'sh0) begin
         if (sum > $signed({10'h000, `LEDPI_DUTY_MAX})) begin
            duty_next = `LEDPI_DUTY_MAX;
         end else begin
            duty_next = sum[23:0];
         end
      end else if (err_sum < 32'sh0) begin
         if (sum > 34'sh0) begin
            duty_next = sum[23:0];
         end else begin
            duty_next = 24'h000000;
         end
      end else if (tgt_zero) begin
         duty_next = 24'h000000;
      end else begin
         duty_next = duty_prev;
      end
   end
endmodule : ledpi_duty_step

// ---- ledpi_regulator.sv ----
// led current pi regulator core with register port
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "ledpi_defs.svh"
module ledpi_regulator import ledpi_pkg::*; (
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire ledpi_bus_t  bus_req,
   output logic [31:0]      bus_rdata,
   input  wire logic        interval_tick,
   output logic             amplifier_enable,
   output logic [1:0]       amplifier_input_select,
   output logic             conv_start,
   input  wire logic        conv_done,
   input  wire logic [15:0] conversion_result,
   output ledpi_pwm_t       pwm_out
);
   ledpi_core_t        s_reg;
   ledpi_core_t        s_next;
   logic               tick_sync;
   logic [23:0]        duty_next;
   logic [9:0]         off_use;
   logic signed [31:0] tgt8;
   logic signed [31:0] corr_now;
   logic signed [31:0] corr_prev;
   logic signed [31:0] err_sum;
   logic               oc_hit;
   logic [15:0]        fb_raw;

   // target register index from a bus address, 3 when none
   function automatic logic [1:0] tgt_idx(input logic [5:0] a);
      unique case (a)
         `LEDPI_ADDR_TGT0: tgt_idx = 2'h0;
         `LEDPI_ADDR_TGT1: tgt_idx = 2'h1;
         `LEDPI_ADDR_TGT2: tgt_idx = 2'h2;
         default:          tgt_idx = 2'h3;
      endcase
   endfunction : tgt_idx

   ledpi_sync u_tick_sync (
      .clock    (clock),
      .rst_b    (rst_b),
      .async_in (interval_tick),
      .sync_out (tick_sync)
   );

   // measurement, offset handling and pi error terms
   always_comb begin
      fb_raw = conversion_result >> `LEDPI_FB_SHIFT;
      fb_raw = fb_raw & `LEDPI_FB_MASK;
      tgt8 = $signed({19'h0, s_reg.tgt[s_reg.ch], 3'h0});
      // the first update has no offset yet: its own sample stands in
      off_use = s_reg.first_done[s_reg.ch] ? s_reg.offset[s_reg.ch]
                                           : s_reg.fb;
      corr_prev = $signed({22'h0, s_reg.fb_old[s_reg.ch]})
                - $signed({22'h0, s_reg.offset[s_reg.ch]});
      corr_now = $signed({22'h0, s_reg.fb})
               - $signed({22'h0, off_use});
      oc_hit = corr_now >= $signed({19'h0, s_reg.thresh});
      // fixed coefficients scaled by 256; the older term is added too
      err_sum = `LEDPI_COEF_A2 * (tgt8 - corr_prev)
              + `LEDPI_COEF_A1 * (tgt8 - corr_now);
   end

   ledpi_duty_step u_duty_step (
      .duty_prev (s_reg.duty[s_reg.ch]),
      .err_sum   (err_sum),
      .tgt_zero  (s_reg.tgt[s_reg.ch] == 10'h000),
      .duty_next (duty_next)
   );

   // sequencer, bus slave and per-channel state
   always_comb begin
      s_next = s_reg;
      // one-cycle outputs fall back unless set below
      s_next.tick_d = tick_sync;
      s_next.pwm.trigger = 1'b0;
      s_next.rdata = 32'h0;
      // register writes
      if (bus_req.wr) begin
         if (bus_req.addr == `LEDPI_ADDR_CTRL) begin
            s_next.enable = bus_req.wdata[`LEDPI_CTRL_EN];
         end
         if (bus_req.addr == `LEDPI_ADDR_THRESH) begin
            s_next.thresh = bus_req.wdata[12:0];
         end
         if (tgt_idx(bus_req.addr) != 2'h3) begin
            s_next.tgt[tgt_idx(bus_req.addr)] = bus_req.wdata[9:0];
         end
         if (bus_req.addr == `LEDPI_ADDR_STATUS) begin
            s_next.oc = s_reg.oc & ~bus_req.wdata[2:0];  // write 1 clears
         end
      end
      // register reads, answered next cycle
      if (bus_req.rd) begin
         if (tgt_idx(bus_req.addr) != 2'h3) begin
            s_next.rdata = {22'h0, s_reg.tgt[tgt_idx(bus_req.addr)]};
         end else begin
            unique case (bus_req.addr)
               `LEDPI_ADDR_CTRL:   s_next.rdata = {31'h0, s_reg.enable};
               `LEDPI_ADDR_THRESH: s_next.rdata = {19'h0, s_reg.thresh};
               `LEDPI_ADDR_STATUS: begin
                  s_next.rdata[`LEDPI_ST_OC_LSB +: 3] = s_reg.oc;
                  s_next.rdata[`LEDPI_ST_BUSY] =
                     s_reg.state != LEDPI_IDLE;
                  s_next.rdata[`LEDPI_ST_CH_LSB +: 2] = s_reg.ch;
               end
               `LEDPI_ADDR_DUTY0: s_next.rdata = {8'h0, s_reg.duty[0]};
               `LEDPI_ADDR_DUTY1: s_next.rdata = {8'h0, s_reg.duty[1]};
               `LEDPI_ADDR_DUTY2: s_next.rdata = {8'h0, s_reg.duty[2]};
               default:           s_next.rdata = 32'h0;
            endcase
         end
      end
      // update sequence
      unique case (s_reg.state)
         LEDPI_IDLE: begin
            // edges that arrive during an update are dropped here
            if (tick_sync && !s_reg.tick_d && s_reg.enable) begin
               s_next.state = LEDPI_SETTLE;
               s_next.cnt = 5'h00;
            end
         end
         LEDPI_SETTLE: begin
            if (s_reg.cnt == `LEDPI_SETTLE_LAST) begin
               s_next.state = LEDPI_CONV;
            end else begin
               s_next.cnt = s_reg.cnt + 5'h01;
            end
         end
         LEDPI_CONV: begin
            s_next.state = LEDPI_WAITC;
         end
         LEDPI_WAITC: begin
            // the result is valid only in the done cycle
            if (conv_done) begin
               s_next.fb = fb_raw[9:0];
               s_next.state = LEDPI_CALC;
            end
         end
         LEDPI_CALC: begin
            if (!s_reg.first_done[s_reg.ch]) begin
               s_next.offset[s_reg.ch] = s_reg.fb;
               s_next.first_done[s_reg.ch] = 1'b1;
            end
            // previous term used the offset held before this update
            s_next.pwm.channel = s_reg.ch;
            if (oc_hit) begin
               s_next.pwm.duty = 16'h0000;
               s_next.oc[s_reg.ch] = 1'b1;         // set beats clear
            end else begin
               s_next.duty[s_reg.ch] = duty_next;
               s_next.pwm.duty =
                  16'(duty_next >> `LEDPI_OUT_SHIFT);
            end
            s_next.pwm.trigger = 1'b1;
            s_next.state = LEDPI_LOAD;
         end
         LEDPI_LOAD: begin
            // raw value kept; the offset comes off again when used
            s_next.fb_old[s_reg.ch] = s_reg.fb;
            s_next.ch = (s_reg.ch == `LEDPI_LAST_CH) ? 2'h0
                      : s_reg.ch + 2'h1;
            s_next.state = LEDPI_IDLE;
         end
         default: begin
            s_next.state = LEDPI_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         s_reg <= '0;
         s_reg.state <= LEDPI_IDLE;
         // threshold starts at its top so nothing trips early
         s_reg.thresh <= `LEDPI_RST_THRESH;
      end else begin
         s_reg <= s_next;
      end
   end

   // outputs
   assign bus_rdata = s_reg.rdata;
   assign amplifier_enable = (s_reg.state != LEDPI_IDLE);
   assign amplifier_input_select = s_reg.ch;
   assign conv_start = (s_reg.state == LEDPI_CONV);
   assign pwm_out = s_reg.pwm;

   // checks, all on the system clock and quiet during reset
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   // the start pulse follows the last settle count directly
   settle_wait_a: assert property (
      $rose(conv_start) |-> $past(s_reg.cnt) == `LEDPI_SETTLE_LAST
                            && $past(s_reg.state) == LEDPI_SETTLE)
      else $error("conversion started before settling");

   // the amplifier was on for exactly the settle time before the start
   amp_before_conv_a: assert property (
      conv_start |-> amplifier_enable && $past(amplifier_enable, 20)
                     && !$past(amplifier_enable, 21))
      else $error("conversion without amplifier on");

   // over-current: zero reload and strobe, accumulator kept, flag set
   oc_zero_a: assert property (
      (s_reg.state == LEDPI_CALC && oc_hit)
      |=> pwm_out.trigger && pwm_out.duty == 16'h0000
          && s_reg.duty[pwm_out.channel]
             == $past(s_reg.duty[s_reg.ch])
          && s_reg.oc[pwm_out.channel])
      else $error("over-current did not zero the duty");

   // the reload carries the upper sixteen bits of the accumulator
   reload_shift_a: assert property (
      (s_reg.state == LEDPI_CALC && !oc_hit)
      |=> pwm_out.duty == $past(duty_next[23:8]) && pwm_out.trigger
          && pwm_out.duty == s_reg.duty[pwm_out.channel][23:8])
      else $error("reload value is not duty shifted by 8");

   // the accumulator never passes the ceiling
   duty_max_a: assert property (
      s_reg.duty[s_reg.ch] <= `LEDPI_DUTY_MAX)
      else $error("duty accumulator above maximum");

   // the lowest measurement bit is always masked off
   fb_mask_a: assert property (
      s_reg.state == LEDPI_CALC |-> s_reg.fb[0] == 1'b0)
      else $error("measurement low bit not masked");

   // the raw measurement is kept for the next previous-error term
   old_store_a: assert property (
      pwm_out.trigger
      |=> s_reg.fb_old[$past(s_reg.ch)] == $past(s_reg.fb))
      else $error("previous measurement not stored");

   // the dark sample of the first update becomes the channel offset
   offset_cap_a: assert property (
      (s_reg.state == LEDPI_CALC && !s_reg.first_done[s_reg.ch])
      |=> s_reg.offset[$past(s_reg.ch)] == $past(s_reg.fb))
      else $error("offset not captured on first update");

   // channels advance 0, 1, 2 and wrap after every reload
   rotate_ch_a: assert property (
      pwm_out.trigger |=> s_reg.ch ==
         (($past(s_reg.ch) == `LEDPI_LAST_CH) ? 2'h0
                                              : $past(s_reg.ch) + 2'h1))
      else $error("channel did not rotate");

   // the reload strobe is a single cycle
   trig_pulse_a: assert property (
      pwm_out.trigger |=> !pwm_out.trigger)
      else $error("reload trigger longer than one cycle");

   // a conversion start is one pulse, then the result is awaited
   conv_pulse_a: assert property (
      conv_start |=> !conv_start && s_reg.state == LEDPI_WAITC)
      else $error("conversion start not a single pulse");

   // the measurement is result bits 15 to 7 above a cleared low bit
   fb_take_a: assert property (
      (s_reg.state == LEDPI_WAITC && conv_done)
      |=> s_reg.fb == {$past(conversion_result[15:7]), 1'b0})
      else $error("measurement not taken from the conversion result");

   // the pi terms see the target register times eight
   tgt_scale_a: assert property (
      s_reg.state == LEDPI_CALC
      |-> tgt8[2:0] == 3'h0 && tgt8[12:3] == s_reg.tgt[s_reg.ch]
          && tgt8[31:13] == 19'h00000)
      else $error("target not scaled by eight");

   // the over-current decision uses the offset-corrected measurement
   oc_corrected_a: assert property (
      (s_reg.state == LEDPI_CALC && s_reg.first_done[s_reg.ch])
      |-> oc_hit == (14'(s_reg.fb)
                     >= 14'(s_reg.offset[s_reg.ch]) + 14'(s_reg.thresh)))
      else $error("over-current not judged on corrected measurement");

   // the dark first sample counts as an over-current only with a zero threshold
   dark_no_oc_a: assert property (
      (s_reg.state == LEDPI_CALC && !s_reg.first_done[s_reg.ch]
       && s_reg.thresh != 13'h0000)
      |-> !oc_hit)
      else $error("first dark sample flagged as over-current");

   // zero target with no correction switches the channel off
   off_force_a: assert property (
      (s_reg.state == LEDPI_CALC && !oc_hit && err_sum == 32'sh0
       && s_reg.tgt[s_reg.ch] == 10'h000)
      |=> s_reg.duty[$past(s_reg.ch)] == 24'h000000)
      else $error("zero target did not switch the duty off");

   // a correction that passes zero leaves the duty at zero
   clamp_low_a: assert property (
      (s_reg.state == LEDPI_CALC && !oc_hit && err_sum < 32'sh0
       && 33'(-err_sum) >= 33'(s_reg.duty[s_reg.ch]))
      |=> s_reg.duty[$past(s_reg.ch)] == 24'h000000)
      else $error("negative correction did not stop at zero");

   // no update starts while the block is switched off
   idle_off_a: assert property (
      (s_reg.state == LEDPI_IDLE && !s_reg.enable) |=> !amplifier_enable)
      else $error("update started while disabled");

   // the input select holds still for the whole update
   sel_hold_a: assert property (
      amplifier_enable && $past(amplifier_enable)
      |-> $stable(amplifier_input_select))
      else $error("input select moved during an update");

   // main scenarios
   oc_seen_c: cover property (s_reg.state == LEDPI_CALC && oc_hit);
   clamp_max_c: cover property (duty_next == `LEDPI_DUTY_MAX
                                && s_reg.state == LEDPI_CALC);
   full_round_c: cover property (pwm_out.trigger
                                 && pwm_out.channel == `LEDPI_LAST_CH);
   clamp_low_c: cover property (s_reg.state == LEDPI_CALC && !oc_hit
                                && err_sum < 32'sh0);
   dark_first_c: cover property (s_reg.state == LEDPI_CALC
                                 && !s_reg.first_done[s_reg.ch]);
endmodule : ledpi_regulator

// ---- ledpi_conv_model.sv ----
// feedback converter model answering conversion starts
`timescale 1ns/1ps
module ledpi_conv_model (
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire logic        conv_start,
   input  wire logic [3:0]  latency,
   input  wire logic [15:0] sample,
   output logic             conv_done,
   output logic [15:0]      conversion_result
);
   logic [3:0] cnt_reg;

   // count the conversion time; result is junk outside the done cycle
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg <= 4'h0;
         conv_done <= 1'b0;
         conversion_result <= 16'h0000;
      end else begin
         conv_done <= 1'b0;
         conversion_result <= ~conversion_result; // changes every cycle
         if (conv_start) begin
            cnt_reg <= latency;
         end else if (cnt_reg == 4'h1) begin
            cnt_reg <= 4'h0;
            conv_done <= 1'b1;
            conversion_result <= sample;
         end else if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
         end
      end
   end
endmodule : ledpi_conv_model

// ---- ledpi_regulator_bench.sv ----
// self-checking bench of the led current pi regulator
`timescale 1ns/1ps
`include "ledpi_defs.svh"
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin \
   fails++; $display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module ledpi_regulator_bench;
   import ledpi_pkg::*;
   logic        clock;
   logic        rst_b;
   ledpi_bus_t  bus_req;
   logic [31:0] bus_rdata;
   logic        interval_tick;
   logic        amplifier_enable;
   logic [1:0]  amplifier_input_select;
   logic        conv_start;
   logic        conv_done;
   logic [15:0] conversion_result;
   ledpi_pwm_t  pwm_out;
   logic [3:0]  lat;
   logic [15:0] sample;
   int          fails, n_checks, ch, thr, n;
   int          off[3], fbo[3], acc[3], tg[3];
   bit          seen[3];

   ledpi_regulator DUT (.clock(clock), .rst_b(rst_b), .bus_req(bus_req),
      .bus_rdata(bus_rdata), .interval_tick(interval_tick),
      .amplifier_enable(amplifier_enable),
      .amplifier_input_select(amplifier_input_select),
      .conv_start(conv_start), .conv_done(conv_done),
      .conversion_result(conversion_result), .pwm_out(pwm_out));

   ledpi_conv_model ADC (.clock(clock), .rst_b(rst_b),
      .conv_start(conv_start), .latency(lat), .sample(sample),
      .conv_done(conv_done), .conversion_result(conversion_result));

   // one register write cycle
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge clock);
      bus_req.addr <= a;
      bus_req.wdata <= d;
      bus_req.wr <= 1'b1;
      @(posedge clock);
      bus_req.wr <= 1'b0;
   endtask : wr

   // one register read cycle, data looked at in the following cycle
   task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
      @(posedge clock);
      bus_req.addr <= a;
      bus_req.rd <= 1'b1;
      @(posedge clock);
      bus_req.rd <= 1'b0;
      #1;
      `CHK(bus_rdata, e)
   endtask : rd_chk

   // one update: reference math, tick, sequencing and reload checks
   task automatic upd(input logic [15:0] raw, input logic [3:0] l);
      int fb, po, corr, err;
      logic [15:0] ed;
      fb = (raw >> 6) & 32'h000003FE;
      po = fbo[ch] - off[ch];
      if (!seen[ch]) off[ch] = fb;
      seen[ch] = 1;
      corr = fb - off[ch];
      ed = 16'h0000;
      if (corr < thr) begin
         err = 32 * (8 * tg[ch] - po) + 185 * (8 * tg[ch] - corr);
         if (err > 0) begin
            acc[ch] = (32'h00FFF000 - acc[ch] >= err) ?
                      acc[ch] + err : 32'h00FFF000;
         end else if (err < 0) begin
            acc[ch] = (acc[ch] > -err) ? acc[ch] + err : 0;
         end else if (tg[ch] == 0) begin
            acc[ch] = 0;
         end
         ed = acc[ch] >> 8;
      end
      fbo[ch] = fb;
      @(posedge clock);
      interval_tick <= 1'b1;
      sample <= raw;
      lat <= l;
      n = 0;
      while (amplifier_enable !== 1'b1 && n < 50) begin
         @(posedge clock);
         #1;
         n++;
      end
      `CHK(amplifier_enable, 1'b1)
      `CHK(amplifier_input_select, ch[1:0])
      n = 0;
      do begin
         @(posedge clock);
         interval_tick <= (n == 4); // a second edge mid-update
         #1;
         n++;
      end while (conv_start !== 1'b1 && n < 40);
      `CHK(n, 20)
      n = 0;
      do begin
         @(posedge clock);
         #1;
         n++;
      end while (pwm_out.trigger !== 1'b1 && n < 60);
      `CHK(pwm_out.trigger, 1'b1)
      `CHK(pwm_out.duty, ed)
      `CHK(pwm_out.channel, ch[1:0])
      `CHK(amplifier_enable, 1'b1)
      @(posedge clock);
      #1;
      `CHK(pwm_out.trigger, 1'b0)
      ch = (ch + 1) % 3;
      repeat (6) @(posedge clock);
      #1;
      `CHK(amplifier_enable, 1'b0)
   endtask : upd

   // write all three targets from the bench copy
   task automatic set_tgt(input int a, input int b, input int c);
      tg[0] = a;
      tg[1] = b;
      tg[2] = c;
      wr(`LEDPI_ADDR_TGT0, a);
      wr(`LEDPI_ADDR_TGT1, b);
      wr(`LEDPI_ADDR_TGT2, c);
   endtask : set_tgt

   // verdict and end of run
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : final_report

   // system clock, 100 ns period
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // watchdog well beyond the expected run time
   initial begin
      #2_000_000;
      fails++;
      final_report();
   end

   // test sequence
   initial begin
      rst_b = 1'b0;
      bus_req = '0;
      interval_tick = 1'b0;
      lat = 4'h1;
      sample = 16'h0000;
      ch = 0;
      thr = 32'h00001FFF;
      repeat (8) @(posedge clock);
      rst_b <= 1'b1;
      rd_chk(`LEDPI_ADDR_CTRL, 32'h00000000);
      rd_chk(`LEDPI_ADDR_THRESH, 32'h00001FFF);
      rd_chk(`LEDPI_ADDR_STATUS, 32'h00000000);
      rd_chk(6'h3C, 32'h00000000);
      wr(`LEDPI_ADDR_DUTY0, 32'h00000123);
      rd_chk(`LEDPI_ADDR_DUTY0, 32'h00000000);
      wr(`LEDPI_ADDR_TGT0, 32'h000003FF);
      rd_chk(`LEDPI_ADDR_TGT0, 32'h000003FF);
      $display("test registers done");
      set_tgt(0, 0, 0);
      wr(`LEDPI_ADDR_CTRL, 32'h00000001);
      for (int i = 0; i < 3; i++) upd(16'h0400 + i * 16'h0080, 4'h1);
      $display("test offset capture done");
      set_tgt(1023, 500, 0);
      for (int i = 0; i < 36; i++) upd(16'h1000, i[0] ? 4'h8 : 4'h1);
      rd_chk(`LEDPI_ADDR_DUTY0, acc[0]);
      rd_chk(`LEDPI_ADDR_DUTY1, acc[1]);
      rd_chk(`LEDPI_ADDR_DUTY2, acc[2]);
      $display("test ramp and clamp done");
      set_tgt(0, 0, 0);
      for (int i = 0; i < 9; i++) upd(16'h4000, 4'h3);
      rd_chk(`LEDPI_ADDR_DUTY0, acc[0]);
      $display("test dimming down done");
      thr = 4;
      wr(`LEDPI_ADDR_THRESH, 32'h00000004);
      upd(16'h1000, 4'h2);
      rd_chk(`LEDPI_ADDR_STATUS, 32'h00000101);
      wr(`LEDPI_ADDR_STATUS, 32'h00000001);
      rd_chk(`LEDPI_ADDR_STATUS, 32'h00000100);
      rd_chk(`LEDPI_ADDR_DUTY0, acc[0]);
      thr = 32'h00001FFF;
      wr(`LEDPI_ADDR_THRESH, 32'h00001FFF);
      $display("test over-current done");
      wr(`LEDPI_ADDR_CTRL, 32'h00000000);
      @(posedge clock);
      interval_tick <= 1'b1;
      repeat (40) @(posedge clock);
      interval_tick <= 1'b0;
      #1;
      `CHK(amplifier_enable, 1'b0)
      $display("test disabled tick done");
      final_report();
   end
endmodule : ledpi_regulator_bench
